/* rtl/pilc_pkg.sv */
package pilc_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned PILC_LINES  = 32;
  localparam int unsigned PILC_ADDR_W = 8;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PILC_OWNER_CTRL_SET    = 8'h00;
  localparam logic [7:0] PILC_OWNER_PERIPH_SET  = 8'h04;
  localparam logic [7:0] PILC_OWNER_STATUS      = 8'h08;
  localparam logic [7:0] PILC_DRIVE_ON_WRITE    = 8'h10;
  localparam logic [7:0] PILC_DRIVE_OFF_WRITE   = 8'h14;
  localparam logic [7:0] PILC_DRIVE_STATUS      = 8'h18;
  localparam logic [7:0] PILC_LEVEL_SET_WRITE   = 8'h30;
  localparam logic [7:0] PILC_LEVEL_CLEAR_WRITE = 8'h34;
  localparam logic [7:0] PILC_LEVEL_OUT_STATUS  = 8'h38;
  localparam logic [7:0] PILC_PIN_LEVEL_STATUS  = 8'h3C;
  localparam logic [7:0] PILC_OPEN_DRAIN_ON     = 8'h50;
  localparam logic [7:0] PILC_OPEN_DRAIN_OFF    = 8'h54;
  localparam logic [7:0] PILC_OPEN_DRAIN_STATUS = 8'h58;
  localparam logic [7:0] PILC_PULLUP_OFF_WRITE  = 8'h60;
  localparam logic [7:0] PILC_PULLUP_ON_WRITE   = 8'h64;
  localparam logic [7:0] PILC_PULLUP_OFF_STATUS = 8'h68;
  localparam logic [7:0] PILC_PERIPH_A_SELECT   = 8'h70;
  localparam logic [7:0] PILC_PERIPH_B_SELECT   = 8'h74;
  localparam logic [7:0] PILC_PERIPH_CHOICE     = 8'h78;
  localparam logic [7:0] PILC_DIRECT_ALLOW      = 8'hA0;
  localparam logic [7:0] PILC_DIRECT_FORBID     = 8'hA4;
  localparam logic [7:0] PILC_DIRECT_MASK       = 8'hA8;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [31:0] PILC_PULLUP_RST = 32'h0000_0000;
  localparam logic [31:0] PILC_CHOICE_RST = 32'h0000_0000;
  localparam logic [31:0] PILC_DRIVE_RST  = 32'h0000_0000;
  localparam logic [31:0] PILC_LEVEL_RST  = 32'h0000_0000;
  localparam logic [31:0] PILC_MASK_RST   = 32'h0000_0000;
  localparam logic [31:0] PILC_ODRAIN_RST = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Per-line configuration carrier
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic owner;
    logic absel;
    logic drive;
    logic level;
    logic odrain;
  } pilc_line_cfg_t;

  typedef struct packed {
    logic oe;
    logic out;
  } pilc_periph_t;

endpackage

/* rtl/pilc_pad_mux.sv */
`timescale 1ns/1ps
module pilc_pad_mux
  import pilc_pkg::*;
(
  input  wire pilc_line_cfg_t cfg_in,
  input  wire pilc_periph_t   periph_a_in,
  input  wire pilc_periph_t   periph_b_in,
  output logic                pad_out_out,
  output logic                pad_oe_out
);

  // ---------------------------------------------------------------------------
  // Output source selection
  // ---------------------------------------------------------------------------
  pilc_periph_t sel;

  always_comb begin
    if (cfg_in.owner) begin
      sel.oe  = cfg_in.drive;
      sel.out = cfg_in.level;
    end else if (cfg_in.absel) begin
      sel = periph_b_in;
    end else begin
      sel = periph_a_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Pad driver, open drain releases a high level
  // ---------------------------------------------------------------------------
  always_comb begin
    if (cfg_in.odrain) begin
      pad_out_out = 1'b0;
      pad_oe_out  = sel.oe & ~sel.out;
    end else begin
      pad_out_out = sel.out;
      pad_oe_out  = sel.oe;
    end
  end

endmodule // pilc_pad_mux

/* rtl/pilc_line_ctrl.sv */
// Summary of operation
// - pull-up on/off writes clear/set status bit
// - status 1 means pull-up off
// - pull-up writes act regardless of configuration
// - all pull-ups on after reset
// - owner writes give line to controller/peripheral
// - unmultiplexed lines ignore owner writes, read 1
// - owner reset value is per-line parameter
// - A/B select writes clear/set choice bit
// - A/B steers outputs only, inputs see pin
// - choice resets to peripheral A
// - A/B writes act while controller owns line
// - peripheral owned line driven by chosen peripheral
// - drive writes set/clear output enable status
// - level writes set/clear driven output level
// - drive and level writes act while peripheral owns
// - direct level write gated by allow mask
// - unauthorised bits stay unchanged on direct write
// - allow mask resets to zero
// - open-drain writes set/clear, drives low only
// - open drain applies to any owner
// - open drain off after reset
// - pin status reads actual pin level
// - absent lines ignore writes, read zero
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
module pilc_line_ctrl
  import pilc_pkg::*;
#(
  parameter logic [31:0] LINE_MASK   = 32'hFFFF_FFFF,
  parameter logic [31:0] PERIPH_MASK = 32'hFFFF_FFFF,
  parameter logic [31:0] OWNER_RST   = 32'hFFFF_FFFF
) (
  input  wire logic                   mclk_in,
  input  wire logic                   rst_n_in,
  input  wire logic [PILC_ADDR_W-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic      [31:0]            avs_readdata_out,
  output logic                        avs_waitrequest_out,
  input  wire logic [31:0]            pad_in_in,
  output logic      [31:0]            pad_out_out,
  output logic      [31:0]            pad_oe_out,
  output logic      [31:0]            pullup_en_out,
  input  wire logic [31:0]            periph_a_oe_in,
  input  wire logic [31:0]            periph_a_out_in,
  input  wire logic [31:0]            periph_b_oe_in,
  input  wire logic [31:0]            periph_b_out_in,
  output logic      [31:0]            periph_a_pin_out,
  output logic      [31:0]            periph_b_pin_out
);

  // ---------------------------------------------------------------------------
  // Fixed line properties
  // ---------------------------------------------------------------------------
  localparam logic [31:0] MUXED     = LINE_MASK & PERIPH_MASK;
  localparam logic [31:0] PLAIN     = LINE_MASK & ~PERIPH_MASK;
  localparam logic [31:0] OWN_RESET = (OWNER_RST & MUXED) | PLAIN;

  function automatic logic [31:0] set_clr(input logic [31:0] cur,
                                          input logic [31:0] set,
                                          input logic [31:0] clr);
    set_clr = (cur | set) & ~clr;
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] be);
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ---------------------------------------------------------------------------
  // Bus slave: one wait cycle, then the answer
  // ---------------------------------------------------------------------------
  logic        ack;
  logic        req;
  logic        wr_acc;
  logic [31:0] wdata;

  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack;
  assign wr_acc              = avs_write_in & ack;
  assign wdata               = avs_writedata_in & lanes(avs_byteenable_in) & LINE_MASK;

  function automatic logic [31:0] wr_to(input logic [7:0] off);
    wr_to = (wr_acc && avs_address_in == off) ? wdata : 32'h0000_0000;
  endfunction

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  logic [31:0] pullup_off;
  logic [31:0] owner;
  logic [31:0] choice;
  logic [31:0] drive;
  logic [31:0] level;
  logic [31:0] wmask;
  logic [31:0] odrain;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      pullup_off <= PILC_PULLUP_RST;
    end else begin
      pullup_off <= set_clr(pullup_off, wr_to(PILC_PULLUP_OFF_WRITE),
                            wr_to(PILC_PULLUP_ON_WRITE));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      owner <= OWN_RESET;
    end else begin
      owner <= (set_clr(owner, wr_to(PILC_OWNER_CTRL_SET), wr_to(PILC_OWNER_PERIPH_SET))
                & MUXED) | PLAIN;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      choice <= PILC_CHOICE_RST;
    end else begin
      choice <= set_clr(choice, wr_to(PILC_PERIPH_B_SELECT),
                        wr_to(PILC_PERIPH_A_SELECT));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      drive <= PILC_DRIVE_RST;
    end else begin
      drive <= set_clr(drive, wr_to(PILC_DRIVE_ON_WRITE),
                       wr_to(PILC_DRIVE_OFF_WRITE));
    end
  end

  logic [31:0] direct;
  assign direct = wr_to(PILC_LEVEL_OUT_STATUS);

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      level <= PILC_LEVEL_RST;
    end else if (wr_acc && avs_address_in == PILC_LEVEL_OUT_STATUS) begin
      level <= (level & ~wmask) | (direct & wmask);
    end else begin
      level <= set_clr(level, wr_to(PILC_LEVEL_SET_WRITE),
                       wr_to(PILC_LEVEL_CLEAR_WRITE));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      wmask <= PILC_MASK_RST;
    end else begin
      wmask <= set_clr(wmask, wr_to(PILC_DIRECT_ALLOW), wr_to(PILC_DIRECT_FORBID));
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      odrain <= PILC_ODRAIN_RST;
    end else begin
      odrain <= set_clr(odrain, wr_to(PILC_OPEN_DRAIN_ON), wr_to(PILC_OPEN_DRAIN_OFF));
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    case (avs_address_in)
      PILC_OWNER_STATUS:      next_rdata = owner;
      PILC_DRIVE_STATUS:      next_rdata = drive;
      PILC_LEVEL_OUT_STATUS:  next_rdata = level;
      PILC_PIN_LEVEL_STATUS:  next_rdata = pad_in_in;
      PILC_OPEN_DRAIN_STATUS: next_rdata = odrain;
      PILC_PULLUP_OFF_STATUS: next_rdata = pullup_off;
      PILC_PERIPH_CHOICE:     next_rdata = choice;
      PILC_DIRECT_MASK:       next_rdata = wmask;
      default:                next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !ack) begin
      avs_readdata_out <= next_rdata & LINE_MASK;
    end
  end

  // ---------------------------------------------------------------------------
  // Pad side
  // ---------------------------------------------------------------------------
  assign pullup_en_out    = ~pullup_off & LINE_MASK;
  assign periph_a_pin_out = pad_in_in;
  assign periph_b_pin_out = pad_in_in;

  for (genvar i = 0; i < PILC_LINES; i++) begin : g_line
    pilc_line_cfg_t cfg;
    pilc_periph_t   pa;
    pilc_periph_t   pb;

    assign cfg = '{owner: owner[i], absel: choice[i], drive: drive[i],
                   level: level[i], odrain: odrain[i]};
    assign pa  = '{oe: periph_a_oe_in[i] & LINE_MASK[i], out: periph_a_out_in[i]};
    assign pb  = '{oe: periph_b_oe_in[i] & LINE_MASK[i], out: periph_b_out_in[i]};

    pilc_pad_mux u_mux (
      .cfg_in      (cfg),
      .periph_a_in (pa),
      .periph_b_in (pb),
      .pad_out_out (pad_out_out[i]),
      .pad_oe_out  (pad_oe_out[i])
    );
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Output level each line would show, for the open-drain check
  logic [31:0] sel_level;

  assign sel_level = (owner & level) | (~owner & ~choice & periph_a_out_in)
                     | (~owner & choice & periph_b_out_in);

  bus_answer_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (req && avs_waitrequest_out) |=> !avs_waitrequest_out)
    else $error("bus answer not given in the second cycle");

  pullup_write_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_acc && avs_address_in == PILC_PULLUP_OFF_WRITE)
    |=> ((pullup_off & $past(wdata)) == $past(wdata))
        && ((pullup_en_out & $past(wdata)) == 32'h0000_0000))
    else $error("pull-up off write did not act");

  pullup_reset_a: assert property (
    @(posedge mclk_in)
    !rst_n_in |=> pullup_en_out == LINE_MASK)
    else $error("pull-ups not on after reset");

  owner_fixed_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (owner & PLAIN) == PLAIN)
    else $error("unmultiplexed line lost controller ownership");

  choice_write_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_acc && avs_address_in == PILC_PERIPH_B_SELECT)
    |=> (choice & $past(wdata)) == $past(wdata))
    else $error("B select write did not act");

  direct_write_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_acc && avs_address_in == PILC_LEVEL_OUT_STATUS)
    |=> level == (($past(level) & ~$past(wmask)) | ($past(wdata) & $past(wmask))))
    else $error("direct level write changed unauthorised bits");

  mask_reset_a: assert property (
    @(posedge mclk_in)
    !rst_n_in |=> (wmask == 32'h0000_0000 && odrain == 32'h0000_0000))
    else $error("mask or open drain not clear after reset");

  odrain_release_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    ((pad_oe_out & odrain & sel_level) == 32'h0000_0000)
    && ((pad_out_out & odrain) == 32'h0000_0000))
    else $error("open-drain line driven high");

  pin_read_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (avs_read_in && !ack && avs_address_in == PILC_PIN_LEVEL_STATUS)
    |=> avs_readdata_out == ($past(pad_in_in) & LINE_MASK))
    else $error("pin status read wrong level");

  periph_drive_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (!owner[0] && !choice[0] && !odrain[0] && LINE_MASK[0])
    |-> (pad_oe_out[0] == periph_a_oe_in[0] && pad_out_out[0] == periph_a_out_in[0]))
    else $error("peripheral A not driving its owned line");

  periph_b_drive_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (!owner[0] && choice[0] && !odrain[0] && LINE_MASK[0])
    |-> (pad_oe_out[0] == periph_b_oe_in[0] && pad_out_out[0] == periph_b_out_in[0]))
    else $error("peripheral B not driving its owned line");

  owner_write_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_acc && avs_address_in == PILC_OWNER_PERIPH_SET)
    |=> (owner & $past(wdata) & MUXED) == 32'h0000_0000)
    else $error("owner release write did not act");

  drive_write_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_acc && avs_address_in == PILC_DRIVE_OFF_WRITE)
    |=> (drive & $past(wdata)) == 32'h0000_0000)
    else $error("drive off write did not act");

  level_write_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_acc && avs_address_in == PILC_LEVEL_SET_WRITE)
    |=> (level & $past(wdata)) == $past(wdata))
    else $error("level set write did not act");

  zero_bits_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_acc && avs_address_in == PILC_DRIVE_ON_WRITE)
    |=> (drive & ~$past(wdata)) == ($past(drive) & ~$past(wdata)))
    else $error("zero bits of a set write changed state");

  mask_write_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_acc && avs_address_in == PILC_DIRECT_ALLOW)
    |=> (wmask & $past(wdata)) == $past(wdata))
    else $error("direct write allow did not act");

  odrain_write_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    (wr_acc && avs_address_in == PILC_OPEN_DRAIN_OFF)
    |=> (odrain & $past(wdata)) == 32'h0000_0000)
    else $error("open drain off write did not act");

  absent_zero_a: assert property (
    @(posedge mclk_in) disable iff (!rst_n_in)
    ((pullup_off | owner | choice | drive | level | wmask | odrain | avs_readdata_out)
      & ~LINE_MASK) == 32'h0000_0000)
    else $error("absent line holds a set bit");

  choice_reset_a: assert property (
    @(posedge mclk_in)
    !rst_n_in |=> (choice == 32'h0000_0000 && owner == OWN_RESET))
    else $error("choice or owner not at reset value");

endmodule // pilc_line_ctrl

/* tb/pilc_far_side.sv */
`timescale 1ns/1ps
module pilc_far_side (
  input  wire logic [31:0] pad_out_in,
  input  wire logic [31:0] pad_oe_in,
  input  wire logic [31:0] pullup_en_in,
  input  wire logic [31:0] ext_level_in,
  output logic      [31:0] pin_out
);
  // ---------------------------------------------------------------------------
  // Pin resolution: own driver, else internal pull-up, else external level
  // ---------------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pad_oe_in[i]) pin_out[i] = pad_out_in[i];
      else if (pullup_en_in[i]) pin_out[i] = 1'b1;
      else pin_out[i] = ext_level_in[i];
    end
  end
endmodule // pilc_far_side

/* tb/pilc_line_ctrl_tb.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module pilc_line_ctrl_tb;
  import pilc_pkg::*;
  localparam logic [31:0] LINES   = 32'h7FFF_FFFF;
  localparam logic [31:0] MUXED   = 32'h0FFF_FFFF;
  localparam logic [31:0] OWN_RST = 32'hFFFF_FFFE;
  localparam logic [7:0]  SET_A [7] = '{PILC_OWNER_CTRL_SET, PILC_DRIVE_ON_WRITE,
    PILC_LEVEL_SET_WRITE, PILC_OPEN_DRAIN_ON, PILC_PULLUP_OFF_WRITE, PILC_PERIPH_B_SELECT,
    PILC_DIRECT_ALLOW};
  localparam logic [7:0]  CLR_A [7] = '{PILC_OWNER_PERIPH_SET, PILC_DRIVE_OFF_WRITE,
    PILC_LEVEL_CLEAR_WRITE, PILC_OPEN_DRAIN_OFF, PILC_PULLUP_ON_WRITE, PILC_PERIPH_A_SELECT,
    PILC_DIRECT_FORBID};
  localparam logic [7:0]  STS_A [7] = '{PILC_OWNER_STATUS, PILC_DRIVE_STATUS,
    PILC_LEVEL_OUT_STATUS, PILC_OPEN_DRAIN_STATUS, PILC_PULLUP_OFF_STATUS, PILC_PERIPH_CHOICE,
    PILC_DIRECT_MASK};
  logic        mclk, rst_n, rd, wr, wait_r;
  logic [7:0]  adr;
  logic [31:0] wdata, rdata, pin, pad_out, pad_oe, pu_en, ext;
  logic [31:0] a_oe, a_out, b_oe, b_out, a_pin, b_pin;
  logic [31:0] m [7];
  int          bad_count, checks_done;

  pilc_line_ctrl #(.LINE_MASK(LINES), .PERIPH_MASK(MUXED), .OWNER_RST(OWN_RST))
    pilc_line_ctrl_i (.mclk_in(mclk), .rst_n_in(rst_n), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_r),
    .pad_in_in(pin), .pad_out_out(pad_out), .pad_oe_out(pad_oe), .pullup_en_out(pu_en),
    .periph_a_oe_in(a_oe), .periph_a_out_in(a_out), .periph_b_oe_in(b_oe),
    .periph_b_out_in(b_out), .periph_a_pin_out(a_pin), .periph_b_pin_out(b_pin));
  pilc_far_side pilc_far_side_i (.pad_out_in(pad_out), .pad_oe_in(pad_oe),
    .pullup_en_in(pu_en), .ext_level_in(ext), .pin_out(pin));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ---------------------------------------------------------------------------
  // Bus and model helpers
  // ---------------------------------------------------------------------------
  task automatic close_out();
    $display("Checks %0d, errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    adr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    q = rdata;
    if (wait_r !== 1'b0) begin
      bad_count++;
      close_out();
    end
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr_r(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus_xfer(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask

  task automatic apply(input int i, input logic s, input logic [31:0] d);
    wr_r(s ? SET_A[i] : CLR_A[i], d);
    m[i] = (s ? (m[i] | d) : (m[i] & ~d)) & LINES;
    if (i == 0) m[0] = (m[0] & MUXED) | (LINES & ~MUXED);
    rd_chk(STS_A[i], m[i]);
  endtask

  task automatic pad_chk();
    logic [31:0] eoe, eout;
    logic        so, sl;
    @(negedge mclk);
    for (int i = 0; i < 32; i++) begin
      so = m[0][i] ? m[1][i] : (m[5][i] ? b_oe[i] : a_oe[i]);
      sl = m[0][i] ? m[2][i] : (m[5][i] ? b_out[i] : a_out[i]);
      eoe[i] = LINES[i] & so & ~(m[3][i] & sl);
      eout[i] = sl & ~m[3][i];
    end
    `CHK(pad_oe, eoe)
    `CHK(pad_out & eoe, eout & eoe)
    `CHK(pu_en, ~m[4] & LINES)
    `CHK(a_pin, pin)
    `CHK(b_pin, pin)
    @(posedge mclk);
    rd_chk(PILC_PIN_LEVEL_STATUS, pin & LINES);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic scn_reset();
    for (int i = 0; i < 7; i++) rd_chk(STS_A[i], m[i]);
    rd_chk(8'h0C, 32'h0);
    pad_chk();
  endtask

  task automatic scn_set_clear();
    for (int i = 0; i < 7; i++) begin
      apply(i, 1'b1, 32'hA5A5_A5A5);
      apply(i, 1'b0, 32'h0000_FFFF);
    end
    pad_chk();
  endtask

  task automatic direct(input logic [31:0] d);
    wr_r(PILC_LEVEL_OUT_STATUS, d);
    m[2] = ((m[2] & ~m[6]) | (d & m[6])) & LINES;
    rd_chk(PILC_LEVEL_OUT_STATUS, m[2]);
  endtask

  task automatic scn_direct();
    direct(32'hFFFF_FFFF);
    apply(6, 1'b1, 32'h0000_00F0);
    direct(32'h0000_0050);
    direct(32'hFFFF_FF0F);
    apply(6, 1'b0, 32'hFFFF_FFFF);
    direct(32'hFFFF_FFFF);
  endtask

  task automatic scn_pads();
    logic [31:0] p;
    apply(5, 1'b1, 32'h0F0F_0F0F);
    apply(1, 1'b1, 32'h3333_3333);
    apply(2, 1'b1, 32'h5555_5555);
    apply(3, 1'b1, 32'h00FF_F0F0);
    apply(0, 1'b0, 32'hF000_FFFF);
    for (int k = 0; k < 4; k++) begin
      p = 32'h6A5C_93E1 ^ (32'h1111_1111 * k);
      a_oe <= p;
      a_out <= ~p ^ 32'h0F0F_0F0F;
      b_oe <= ~p;
      b_out <= {p[15:0], p[31:16]};
      ext <= p ^ 32'hFFFF_0000;
      @(posedge mclk);
      pad_chk();
    end
    apply(4, 1'b1, 32'h00FF_00FF);
    pad_chk();
    apply(0, 1'b1, 32'hFFFF_FFFF);
    pad_chk();
  endtask

  initial begin
    bad_count = 0;
    checks_done = 0;
    rst_n = 1'b0;
    {rd, wr, adr, wdata} = '0;
    {a_oe, a_out, b_oe, b_out} = '0;
    ext = 32'h9C36_A5F0;
    m = '{32'h7FFF_FFFE, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    scn_reset();
    scn_set_clear();
    scn_direct();
    scn_pads();
    close_out();
  end
endmodule // pilc_line_ctrl_tb
